// File: rtl/prsc_pkg.sv
package prsc_pkg;

  // Lanes served by one controller at most (eight-lane bonding)
  localparam int unsigned NUM_LANES = 8;

  // Datapath figures for the two rates
  localparam logic [9:0] GEN1_PCLK_MHZ = 10'h0FA;
  localparam logic [9:0] GEN2_PCLK_MHZ = 10'h1F4;
  localparam logic [4:0] IF_WIDTH_BITS = 5'h10;

  // Comma code group that marks electrical idle exit
  localparam logic [7:0] COM_SYMBOL = 8'hBC;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_EVENT = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  localparam logic [7:0] OFS_INFO = 8'h10;

  // Control register fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_CU0_BIT = 2;
  localparam int unsigned CTRL_MASTER_BIT = 3;
  localparam int unsigned CTRL_EN_BIT = 4;

  // Event register fields, write one to clear
  localparam int unsigned EVT_COM_BIT = 0;
  localparam int unsigned EVT_SW_BIT = 1;

  // Info register field positions
  localparam int unsigned INFO_G2_LSB = 10;
  localparam int unsigned INFO_W_LSB = 20;

  // Lane-count mode codes
  localparam logic [1:0] LANE_X1 = 2'h0;
  localparam logic [1:0] LANE_X4 = 2'h1;
  localparam logic [1:0] LANE_X8 = 2'h2;

  // Reset values of the control fields
  localparam logic [1:0] RST_MODE = LANE_X1;
  localparam logic RST_CU0 = 1'b1;
  localparam logic RST_MASTER = 1'b1;
  localparam logic RST_EN = 1'b1;

endpackage

// File: rtl/prsc_if.sv
`timescale 1ns/1ps
`default_nettype none

// Internal links between controller, rate-select edge
// finder and the completion pulse stage
interface prsc_if;
  logic lvl;
  logic rise;
  logic fall;
  logic done_evt;
  logic [7:0] lane_mask;
  logic [7:0] phy_done;

  modport sync_mp (output lvl, output rise, output fall);
  modport pulse_mp (input done_evt, input lane_mask,
                    output phy_done);
  modport ctl_mp (input lvl, input rise, input fall,
                  input phy_done, output done_evt,
                  output lane_mask);
endinterface

`default_nettype wire

// File: rtl/prsc_rate_edge.sv
`timescale 1ns/1ps
`default_nettype none

// Synchroniser and edge finder for the rate-select level
module prsc_rate_edge (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rate_sel_i,
  input wire logic force_gen1_i,
  prsc_if.sync_mp lk
);

  // Two sync stages and the previous effective level
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } prsc_edge_t;

  prsc_edge_t q_reg;
  prsc_edge_t q_next;
  logic eff;

  // A forced first-generation level masks the request
  assign eff = q_reg.s2 & ~force_gen1_i;

  // Next state; the first stage feeds only the second
  always_comb begin
    q_next = q_reg;
    q_next.s1 = rate_sel_i;
    q_next.s2 = q_reg.s1;
    q_next.prev = eff;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign lk.lvl = eff;
  assign lk.rise = eff & ~q_reg.prev;
  assign lk.fall = ~eff & q_reg.prev;

endmodule

`default_nettype wire

// File: rtl/prsc_done_pulse.sv
`timescale 1ns/1ps
`default_nettype none

// Completion stage: one parallel-clock pulse on each
// bonded channel's phy-done output
module prsc_done_pulse (
  input wire logic clk_i,
  input wire logic rst_n_i,
  prsc_if.pulse_mp lk
);

  typedef struct packed {
    logic [7:0] done;
  } prsc_pulse_t;

  prsc_pulse_t q_reg;
  prsc_pulse_t q_next;

  // Every bonded lane sees the same cycle
  always_comb begin
    q_next = q_reg;
    for (int i = 0; i < 8; i++) begin
      q_next.done[i] = lk.done_evt & lk.lane_mask[i];
    end
  end

  // Cleared each cycle unless a new event arrives
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign lk.phy_done = q_reg.done;

endmodule

`default_nettype wire

// File: rtl/prsc_ctrl.sv
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module prsc_ctrl (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Rate request from the PHY-MAC
  input wire logic RATE_SEL_I,
  // Receive PCS digital reset
  input wire logic RX_DIGITAL_RESET_I,
  // Clock switch circuitry
  input wire logic SPEED_CHANGE_DONE_I,
  output logic SPEED_CHANGE_CMD_O,
  output logic TX_SW_LOCAL_O,
  output logic TX_SW_CLOCK_UNIT_ZERO_O,
  output logic [7:0] CDR_RATE_O,
  // Phase compensation FIFO pointer resets
  output logic TX_FIFO_PTR_RST_O,
  output logic RX_FIFO_PTR_RST_O,
  // Receive symbol stream
  input wire logic [7:0] RX_DATA_I,
  input wire logic RX_DATA_K_I,
  output logic ELEC_IDLE_EXIT_O,
  // Status toward the PHY-MAC
  output logic [7:0] PHY_DONE_O,
  output logic RATE_GEN2_O
);

  // Switch sequencer states
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_SWITCH
  } prsc_state_t;

  // All controller state in one word
  typedef struct packed {
    prsc_state_t st; // Sequencer state
    logic target; // Rate being switched to
    logic rate; // Rate now in force, high is gen2
    logic cmd; // Level sent to the clock switch
    logic [1:0] mode; // Lane-count mode
    logic cu0; // This is the clock-unit-zero channel
    logic master; // This block is the bonding master
    logic en; // Software enable of the controller
    logic com_seen; // Sticky COM received flag
    logic sw_seen; // Sticky switch completed flag
    logic [15:0] count; // Completed switches
    logic done_evt; // Completion handed to pulse stage
    logic eie; // Electrical idle exit pulse
    logic [31:0] prdata; // Read data for the access phase
    logic slverr; // Error flag for the access phase
  } prsc_ctl_t;

  prsc_ctl_t q_reg;
  prsc_ctl_t q_next;

  prsc_if lk ();

  // Bus decode helpers
  logic setup_ph; // First cycle of a transfer
  logic wr_acc; // Write takes effect here
  logic active; // Controller placed in this channel
  logic start; // A switch begins this cycle
  logic com_hit; // COM symbol on the receive stream
  logic [31:0] rd_mux; // Read data chosen by address
  logic rd_bad; // Address not mapped

  // Lanes that belong to this controller's group
  function automatic logic [7:0] lane_mask_f(
    input logic [1:0] mode
  );
    logic [7:0] m;
    m = 8'h01;
    case (mode)
      prsc_pkg::LANE_X4: begin
        m = 8'h0F;
      end
      prsc_pkg::LANE_X8: begin
        m = 8'hFF;
      end
      default: begin
        m = 8'h01;
      end
    endcase
    return m;
  endfunction

  // Whether the controller of this channel is the live one
  function automatic logic placed_f(
    input logic [1:0] mode,
    input logic cu0,
    input logic master
  );
    logic p;
    p = 1'b0;
    case (mode)
      prsc_pkg::LANE_X1: begin
        p = 1'b1;
      end
      prsc_pkg::LANE_X4: begin
        p = cu0;
      end
      prsc_pkg::LANE_X8: begin
        p = cu0 & master;
      end
      default: begin
        p = 1'b0;
      end
    endcase
    return p;
  endfunction

  // Select level is synchronised; the digital reset masks
  // it so that a gen2 link drops back to gen1
  prsc_rate_edge u_edge (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .rate_sel_i(RATE_SEL_I),
    .force_gen1_i(RX_DIGITAL_RESET_I),
    .lk(lk.sync_mp)
  );

  // Completion pulse stage for the phy-done outputs
  prsc_done_pulse u_pulse (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .lk(lk.pulse_mp)
  );

  assign active = q_reg.en &
    placed_f(q_reg.mode, q_reg.cu0, q_reg.master);

  assign setup_ph = PSEL_I & ~PENABLE_I;
  assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I;

  // An edge starts a switch; a level left different from
  // the rate by an edge seen while busy starts one later,
  // so no request is lost but none overlaps another
  assign start = active && (q_reg.st == ST_IDLE) &&
    (lk.rise || lk.fall || (lk.lvl != q_reg.rate));

  assign com_hit = RX_DATA_K_I &&
    (RX_DATA_I == prsc_pkg::COM_SYMBOL);

  // Read data by address; unmapped answers with an error
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_bad = 1'b0;
    case (PADDR_I)
      prsc_pkg::OFS_CTRL: begin
        rd_mux[prsc_pkg::CTRL_MODE_LSB +: 2] = q_reg.mode;
        rd_mux[prsc_pkg::CTRL_CU0_BIT] = q_reg.cu0;
        rd_mux[prsc_pkg::CTRL_MASTER_BIT] = q_reg.master;
        rd_mux[prsc_pkg::CTRL_EN_BIT] = q_reg.en;
      end
      prsc_pkg::OFS_STATUS: begin
        rd_mux[0] = q_reg.rate;
        rd_mux[1] = (q_reg.st == ST_SWITCH);
        rd_mux[2] = q_reg.cmd;
        rd_mux[3] = TX_FIFO_PTR_RST_O;
        rd_mux[4] = lk.lvl;
        rd_mux[5] = active;
      end
      prsc_pkg::OFS_EVENT: begin
        rd_mux[prsc_pkg::EVT_COM_BIT] = q_reg.com_seen;
        rd_mux[prsc_pkg::EVT_SW_BIT] = q_reg.sw_seen;
      end
      prsc_pkg::OFS_COUNT: begin
        rd_mux[15:0] = q_reg.count;
      end
      prsc_pkg::OFS_INFO: begin
        rd_mux[9:0] = prsc_pkg::GEN1_PCLK_MHZ;
        rd_mux[prsc_pkg::INFO_G2_LSB +: 10] =
          prsc_pkg::GEN2_PCLK_MHZ;
        rd_mux[prsc_pkg::INFO_W_LSB +: 5] =
          prsc_pkg::IF_WIDTH_BITS;
      end
      default: begin
        rd_bad = 1'b1;
      end
    endcase
  end

  // Next-state logic for the whole controller
  always_comb begin
    q_next = q_reg;
    q_next.done_evt = 1'b0;
    q_next.eie = com_hit;

    // Read data and error are caught in the setup cycle so
    // that the access cycle presents flip-flop outputs
    if (setup_ph) begin
      q_next.prdata = PWRITE_I ? 32'h0000_0000 : rd_mux;
      q_next.slverr = rd_bad;
    end

    // Control writes; placement is only changed while idle
    // would be safer, but software owns that ordering
    if (wr_acc && (PADDR_I == prsc_pkg::OFS_CTRL)) begin
      q_next.mode = PWDATA_I[prsc_pkg::CTRL_MODE_LSB +: 2];
      q_next.cu0 = PWDATA_I[prsc_pkg::CTRL_CU0_BIT];
      q_next.master = PWDATA_I[prsc_pkg::CTRL_MASTER_BIT];
      q_next.en = PWDATA_I[prsc_pkg::CTRL_EN_BIT];
    end

    // Sticky flags: a set in the clearing cycle wins
    if (wr_acc && (PADDR_I == prsc_pkg::OFS_EVENT)) begin
      if (PWDATA_I[prsc_pkg::EVT_COM_BIT]) begin
        q_next.com_seen = 1'b0;
      end
      if (PWDATA_I[prsc_pkg::EVT_SW_BIT]) begin
        q_next.sw_seen = 1'b0;
      end
    end
    if (com_hit) begin
      q_next.com_seen = 1'b1;
    end

    // Switch sequencer
    case (q_reg.st)
      ST_IDLE: begin
        if (start) begin
          // The command follows the new select level
          q_next.target = lk.lvl;
          q_next.cmd = lk.lvl;
          q_next.st = ST_SWITCH;
        end
      end
      ST_SWITCH: begin
        // Only the done line ends the switch; edges seen
        // meanwhile wait until the sequencer is idle again
        if (SPEED_CHANGE_DONE_I) begin
          q_next.rate = q_reg.target;
          q_next.done_evt = 1'b1;
          q_next.sw_seen = 1'b1;
          q_next.count = q_reg.count + 16'h0001;
          q_next.st = ST_IDLE;
        end
      end
      default: begin
        q_next.st = ST_IDLE;
      end
    endcase
  end

  // State register; reset leaves the link at gen1
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q_reg <= '0;
      q_reg.st <= ST_IDLE;
      q_reg.mode <= prsc_pkg::RST_MODE;
      q_reg.cu0 <= prsc_pkg::RST_CU0;
      q_reg.master <= prsc_pkg::RST_MASTER;
      q_reg.en <= prsc_pkg::RST_EN;
    end else begin
      q_reg <= q_next;
    end
  end

  // Completion and bonded lanes handed to pulse stage
  assign lk.done_evt = q_reg.done_evt;
  assign lk.lane_mask = lane_mask_f(q_reg.mode);

  // Phy-done comes from the pulse stage's register and so
  // cannot rise while the switch is still running
  assign PHY_DONE_O = lk.phy_done;

  // Pointers held from the first switch cycle; released
  // combinationally in the cycle the done line is seen
  assign TX_FIFO_PTR_RST_O = (q_reg.st == ST_SWITCH) &&
    !SPEED_CHANGE_DONE_I;
  assign RX_FIFO_PTR_RST_O = TX_FIFO_PTR_RST_O;

  // One command register drives every clock switch, so the
  // serial, parallel and recovered clocks cannot disagree;
  // high selects the 500 MHz parallel clock
  assign SPEED_CHANGE_CMD_O = q_reg.cmd;

  // Transmit switch point depends on lane mode
  assign TX_SW_LOCAL_O = q_reg.cmd &&
    (q_reg.mode == prsc_pkg::LANE_X1);
  assign TX_SW_CLOCK_UNIT_ZERO_O = q_reg.cmd &&
    (q_reg.mode != prsc_pkg::LANE_X1);

  // Each channel CDR of the group switches with the one command
  generate
    for (genvar g = 0; g < prsc_pkg::NUM_LANES; g++) begin : g_cdr
      assign CDR_RATE_O[g] = q_reg.cmd &
        lk.lane_mask[g];
    end
  endgenerate

  assign RATE_GEN2_O = q_reg.rate;
  assign ELEC_IDLE_EXIT_O = q_reg.eie;

  // Zero-wait slave: every access phase completes at once
  assign PREADY_O = 1'b1;
  assign PRDATA_O = q_reg.prdata;
  assign PSLVERR_O = q_reg.slverr & PSEL_I & PENABLE_I;

endmodule

`default_nettype wire

// File: sim/prsc_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none

// Timing checks on the rate-switch ports
module prsc_ctrl_properties (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic SPEED_CHANGE_DONE_I,
  input wire logic SPEED_CHANGE_CMD_O,
  input wire logic TX_SW_LOCAL_O,
  input wire logic TX_SW_CLOCK_UNIT_ZERO_O,
  input wire logic [7:0] CDR_RATE_O,
  input wire logic TX_FIFO_PTR_RST_O,
  input wire logic RX_FIFO_PTR_RST_O,
  input wire logic [7:0] RX_DATA_I,
  input wire logic RX_DATA_K_I,
  input wire logic ELEC_IDLE_EXIT_O,
  input wire logic [7:0] PHY_DONE_O,
  input wire logic RATE_GEN2_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  // A running switch meets its done indication
  sequence s_sw_end;
    $past(TX_FIFO_PTR_RST_O) && SPEED_CHANGE_DONE_I;
  endsequence
  // Second and later cycles of a switch
  sequence s_sw_run;
    TX_FIFO_PTR_RST_O && $past(TX_FIFO_PTR_RST_O);
  endsequence

  property p_ptr_pair;
    TX_FIFO_PTR_RST_O == RX_FIFO_PTR_RST_O;
  endproperty
  a_ptr_pair: assert property (p_ptr_pair) else $error("fifo resets differ");
  property p_ptr_hold;
    TX_FIFO_PTR_RST_O && !SPEED_CHANGE_DONE_I |=> TX_FIFO_PTR_RST_O || SPEED_CHANGE_DONE_I;
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("fifo reset dropped early");
  property p_ptr_release;
    s_sw_end |-> !TX_FIFO_PTR_RST_O;
  endproperty
  a_ptr_release: assert property (p_ptr_release) else $error("fifo reset not released");
  property p_done_pulse;
    s_sw_end |=> ##1 PHY_DONE_O[0] ##1 !PHY_DONE_O[0];
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("phy done pulse wrong");
  property p_rate_follow;
    s_sw_end |=> RATE_GEN2_O == SPEED_CHANGE_CMD_O;
  endproperty
  a_rate_follow: assert property (p_rate_follow) else $error("rate not updated");
  property p_one_switch;
    s_sw_run |-> $stable(SPEED_CHANGE_CMD_O) && PHY_DONE_O == 8'h00;
  endproperty
  a_one_switch: assert property (p_one_switch) else $error("switch disturbed");
  property p_cdr_lane0;
    CDR_RATE_O[0] == SPEED_CHANGE_CMD_O;
  endproperty
  a_cdr_lane0: assert property (p_cdr_lane0) else $error("cdr rate differs");
  property p_tx_sw;
    !(TX_SW_LOCAL_O && TX_SW_CLOCK_UNIT_ZERO_O) and ((TX_SW_LOCAL_O || TX_SW_CLOCK_UNIT_ZERO_O) |-> SPEED_CHANGE_CMD_O);
  endproperty
  a_tx_sw: assert property (p_tx_sw) else $error("tx switch select wrong");
  property p_com;
    RX_DATA_K_I && RX_DATA_I == prsc_pkg::COM_SYMBOL |=> ELEC_IDLE_EXIT_O;
  endproperty
  a_com: assert property (p_com) else $error("idle exit missed");
endmodule

`default_nettype wire

// File: sim/prsc_clk_sw_model.sv
`timescale 1ns/1ps
`default_nettype none

// Clock switch circuitry: answers each command change after a set delay
module prsc_clk_sw_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_i,
  input wire logic [7:0] dly_i,
  output logic done_o
);
  logic prev_reg; // Last seen command level
  logic [7:0] cnt_reg; // Cycles left until done
  // Separate done wire, one-cycle report per switch
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_reg <= 1'b0;
      cnt_reg <= 8'h00;
      done_o <= 1'b0;
    end else begin
      prev_reg <= cmd_i;
      done_o <= 1'b0;
      if (cmd_i != prev_reg) begin
        cnt_reg <= dly_i; // Any delay above zero keeps done clear of the start edge; a zero delay never raises done
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
        done_o <= (cnt_reg == 8'h01);
      end
    end
  end
endmodule

`default_nettype wire

// File: sim/prsc_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none

module prsc_ctrl_bench;
  logic CLOCK_I = 1'b0, RST_N_I = 1'b0, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
  logic [7:0] PADDR_I = 8'h00, RX_DATA_I = 8'h00, PHY_DONE_O, CDR_RATE_O, sw_dly = 8'h02;
  logic [31:0] PWDATA_I = 32'h0, PRDATA_O, rd;
  logic RATE_SEL_I = 1'b0, RX_DIGITAL_RESET_I = 1'b0, RX_DATA_K_I = 1'b0, er;
  logic PREADY_O, PSLVERR_O, SPEED_CHANGE_DONE_I, SPEED_CHANGE_CMD_O, TX_SW_LOCAL_O;
  logic TX_SW_CLOCK_UNIT_ZERO_O, TX_FIFO_PTR_RST_O, RX_FIFO_PTR_RST_O, ELEC_IDLE_EXIT_O, RATE_GEN2_O;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  logic [7:0] mask [3] = '{8'h01, 8'h0F, 8'hFF}; // Bonded lanes per mode

  prsc_ctrl dut (.CLOCK_I, .RST_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
    .PRDATA_O, .PREADY_O, .PSLVERR_O, .RATE_SEL_I, .RX_DIGITAL_RESET_I, .SPEED_CHANGE_DONE_I,
    .SPEED_CHANGE_CMD_O, .TX_SW_LOCAL_O, .TX_SW_CLOCK_UNIT_ZERO_O, .CDR_RATE_O, .TX_FIFO_PTR_RST_O,
    .RX_FIFO_PTR_RST_O, .RX_DATA_I, .RX_DATA_K_I, .ELEC_IDLE_EXIT_O, .PHY_DONE_O, .RATE_GEN2_O);
  prsc_clk_sw_model sw (.clk_i(CLOCK_I), .rst_n_i(RST_N_I), .cmd_i(SPEED_CHANGE_CMD_O),
    .dly_i(sw_dly), .done_o(SPEED_CHANGE_DONE_I));

  // 25 MHz clock and hang guard
  always #20 CLOCK_I = ~CLOCK_I;
  always @(posedge CLOCK_I) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK_I);
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge CLOCK_I);
    PENABLE_I <= 1'b1;
    do @(posedge CLOCK_I); while (PREADY_O !== 1'b1);
    rd = PRDATA_O;
    er = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask

  // Bounded wait for the completion pulse
  task automatic wait_done();
    int n;
    for (n = 0; n < 200; n++) begin
      @(posedge CLOCK_I);
      #1;
      if (PHY_DONE_O !== 8'h00) break;
    end
    if (n == 200) chk(32'h0, 32'h1);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge CLOCK_I);
    RST_N_I <= 1'b1;
    #1 chk(RATE_GEN2_O, 1'b0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1C);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0107D0FA);
    // Unmapped address answers with an error and zero data
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    // Each lane mode, alternating direction, slower answers each time
    for (int i = 0; i < 3; i++) begin
      sw_dly <= 8'(2 + 9 * i);
      apb(1'b1, 8'h00, 32'h1C | i);
      // Link sits in P0 with an idle transmitter; tap settings stay with the far side
      RATE_SEL_I <= ~RATE_SEL_I;
      wait_done();
      chk(PHY_DONE_O, mask[i]);
      chk(RATE_GEN2_O, RATE_SEL_I);
      chk(CDR_RATE_O, RATE_SEL_I ? mask[i] : 8'h00);
      chk({TX_SW_LOCAL_O, TX_SW_CLOCK_UNIT_ZERO_O}, RATE_SEL_I ? (i == 0 ? 2'b10 : 2'b01) : 2'b00);
    end
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd[15:0], 16'h0003);
    // Idle at gen2: rate, command, select level and placement all set
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h35);
    // Switch-done flag is set, then cleared by writing one
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, 8'h08, 32'h2);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    // Receive digital reset forces the lower rate, then the select wins back
    @(posedge CLOCK_I);
    RX_DIGITAL_RESET_I <= 1'b1;
    wait_done();
    chk(RATE_GEN2_O, 1'b0);
    @(posedge CLOCK_I);
    RX_DIGITAL_RESET_I <= 1'b0;
    wait_done();
    chk(RATE_GEN2_O, 1'b1);
    // Four-lane mode without clock-unit-zero placement must not switch
    apb(1'b1, 8'h00, 32'h19);
    RATE_SEL_I <= 1'b0;
    repeat (10) @(posedge CLOCK_I);
    #1 chk(SPEED_CHANGE_CMD_O, 1'b1);
    apb(1'b1, 8'h00, 32'h1C);
    wait_done();
    chk(RATE_GEN2_O, 1'b0);
    // Comma symbol gives idle exit one cycle later
    @(posedge CLOCK_I);
    RX_DATA_I <= 8'hBC;
    RX_DATA_K_I <= 1'b1;
    @(posedge CLOCK_I);
    RX_DATA_K_I <= 1'b0;
    #1 chk(ELEC_IDLE_EXIT_O, 1'b1);
    // Both sticky flags now set: COM seen and later switches done
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h3);
    tally_and_finish();
  end
endmodule

bind prsc_ctrl prsc_ctrl_properties u_props (.CLOCK_I, .RST_N_I, .SPEED_CHANGE_DONE_I,
  .SPEED_CHANGE_CMD_O, .TX_SW_LOCAL_O, .TX_SW_CLOCK_UNIT_ZERO_O, .CDR_RATE_O, .TX_FIFO_PTR_RST_O,
  .RX_FIFO_PTR_RST_O, .RX_DATA_I, .RX_DATA_K_I, .ELEC_IDLE_EXIT_O, .PHY_DONE_O, .RATE_GEN2_O);

`default_nettype wire
